// [pkg/touch_defines.svh]
/*
  Register offsets, field positions, reset values and saturation limits
  of the touch controller register bank.
  Assumes inclusion by bare name from design files.
*/
`ifndef TOUCH_DEFINES_SVH
`define TOUCH_DEFINES_SVH

`define OFS_MAIN_CONTROL 8'h00
`define OFS_GENERAL_STATUS 8'h02
`define OFS_INPUT_TOUCH_STATUS 8'h03
`define OFS_LAMP_DONE_STATUS 8'h04
`define OFS_NOISE_FLAGS 8'h0A
`define OFS_INPUT1_DELTA 8'h10
`define OFS_INPUT2_DELTA 8'h11
`define OFS_INPUT3_DELTA 8'h12

`define MAIN_GAIN_HI 7
`define MAIN_GAIN_LO 6
`define MAIN_WATCH_BIT 5
`define MAIN_DOZE_BIT 4
`define MAIN_IRQ_BIT 0

`define GEN_LAMP_BIT 4
`define GEN_GROUP_BIT 2
`define GEN_PATTERN_BIT 1
`define GEN_CONTACT_BIT 0

`define RESET_BYTE 8'h00
`define UNMAPPED_BYTE 8'h00
`define DELTA_MAX 8'h7F
`define DELTA_MIN 8'h80
`define RAW_MAX 16'sh007F
`define RAW_MIN -16'sh0080

`endif

// [pkg/touch_pkg.sv]
/*
  Types shared by the touch controller register bank.
  Assumes nothing of its surroundings.
*/
package touch_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_WATCH, PWR_DOZE} power_mode_t;
endpackage

// [hdl/touch_ctrl_status_regs.sv]
/*
  Control and status register bank of a three-input touch controller.
  Assumes the serial engine presents register accesses on link_clk, one at a
  time, waiting for lk_ack; analog front end and lamp logic run on clk.
*/
`timescale 1ns/100ps
`include "touch_defines.svh"

// Overview of operation
// [R1] Top two main control bits pick gain 1, 2, 4 or 8, in every mode.
// [R2] In watch mode only standby inputs scan; a touch status read also clears touch bits.
// [R3] An input dropped by watch mode releases once, then stays untouched.
// [R4] In watch mode linked lamps keep following; manual lamps stay as they are.
// [R5] Doze stops all scanning, idles every lamp and halts PWM.
// [R6] Entering doze clears every status bit and the interrupt pending bit.
// [R7] Interrupt pending bit drives the low alert pin; enabled touches set it.
// [R8] Touches on channels without interrupt enable never raise the alert.
// [R9] Host writes 0 to clear pending; alert drops, finished status clears.
// [R10] Lamp summary bit reads 1 while any lamp done bit is 1.
// [R11] Group block flag shows blocked touches and never raises an interrupt.
// [R12] Pattern flag follows its condition; interrupts only with pattern enable.
// [R13] Contact summary bit reads 1 while any input touch bit is 1.
// [R14] Touch bit clears on pending clear only once the touch is gone.
// [R15] Lamp done bits set on host lamp finish, ignored if linked, cleared.
// [R16] A noisy input has its delta forced to zero, so no touch.
// [R17] Noise flags follow the front end and never latch.
// [R18] With pattern detect on, noisy inputs count above threshold, once only.
// [R19] Low frequency or RF noisy samples are dropped unless bypassed.
// [R20] Delta registers hold signed bytes, refreshed once per input per cycle.
// [R21] Delta saturates at 7F upward and 80 downward.
// [R22] Unmapped addresses read zero and ignore writes.
// [R23] Unused bits read zero; the alert output is active low.
module touch_ctrl_status_regs
  import touch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic lk_rst,
  input wire logic lk_req,
  input wire logic lk_wr,
  input wire logic [7:0] lk_addr,
  input wire logic [7:0] lk_wdata,
  output logic lk_ack,
  output logic [7:0] lk_rdata,
  input wire logic sample_valid,
  input wire logic [1:0] sample_idx,
  input wire logic signed [15:0] sample_delta,
  input wire logic sample_lf_noise,
  input wire logic sample_rf_noise,
  input wire logic lf_filter_bypass,
  input wire logic rf_filter_bypass,
  input wire logic [2:0] noise_err,
  input wire logic [2:0] touch_raw,
  input wire logic [2:0] irq_enable,
  input wire logic [2:0] standby_chan,
  input wire logic multi_block,
  input wire logic pattern_en,
  input wire logic pattern_match,
  input wire logic [2:0] above_pattern,
  input wire logic [1:0] pattern_thresh,
  input wire logic pattern_irq_enable,
  input wire logic [2:0] lamp_linked,
  input wire logic [2:0] lamp_done_evt,
  output logic [2:0] scan_enable,
  output logic [3:0] gain_factor,
  output logic [2:0] lamp_follow,
  output logic lamp_idle,
  output logic pwm_enable,
  output logic irq_out_n
);

  // Link side: hold the request stable and toggle towards the core
  logic req_tgl_ff;
  logic lk_wr_ff;
  logic [7:0] lk_addr_ff;
  logic [7:0] lk_wdata_ff;
  logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
  logic lk_ack_ff;
  logic [7:0] lk_rdata_ff;
  logic ack_tgl_ff;
  reg_byte_t rdata_ff;

  always_ff @(posedge link_clk) begin
    if (lk_rst) begin
      req_tgl_ff <= 1'b0;
      lk_wr_ff <= 1'b0;
      lk_addr_ff <= 8'h00;
      lk_wdata_ff <= 8'h00;
    end else if (lk_req) begin
      req_tgl_ff <= ~req_tgl_ff;
      lk_wr_ff <= lk_wr;
      lk_addr_ff <= lk_addr;
      lk_wdata_ff <= lk_wdata;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lk_rst) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
      lk_ack_ff <= 1'b0;
      lk_rdata_ff <= 8'h00;
    end else begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      lk_ack_ff <= ack_s2_ff ^ ack_s3_ff;
      // Core read data is quiet once its toggle has crossed
      if (ack_s2_ff ^ ack_s3_ff) begin
        lk_rdata_ff <= rdata_ff;
      end
    end
  end

  assign lk_ack = lk_ack_ff;
  assign lk_rdata = lk_rdata_ff;

  // Core side of the handshake
  logic req_s1_ff, req_s2_ff, req_s3_ff;
  logic acc_go, acc_wr, acc_rd;

  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  // Address and data stood still for two clk edges before this is seen
  assign acc_go = req_s2_ff ^ req_s3_ff;
  assign acc_wr = acc_go & lk_wr_ff;
  assign acc_rd = acc_go & ~lk_wr_ff;

  // Main control
  logic [1:0] gain_ff;
  logic watch_ff;
  logic doze_ff;
  logic irq_pending_ff;
  logic main_wr, int_clr, doze_enter, rd_touch;
  power_mode_t mode;

  assign main_wr = acc_wr && lk_addr_ff == `OFS_MAIN_CONTROL;
  assign int_clr = main_wr && !lk_wdata_ff[`MAIN_IRQ_BIT]; // [R9]
  assign doze_enter = main_wr && lk_wdata_ff[`MAIN_DOZE_BIT] && !doze_ff;
  assign rd_touch = acc_rd && lk_addr_ff == `OFS_INPUT_TOUCH_STATUS;

  always_comb begin
    if (doze_ff) begin
      mode = PWR_DOZE;
    end else if (watch_ff) begin
      mode = PWR_WATCH;
    end else begin
      mode = PWR_ACTIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_ff <= 2'h0;
      watch_ff <= 1'b0;
      doze_ff <= 1'b0;
    end else if (main_wr) begin
      gain_ff <= lk_wdata_ff[`MAIN_GAIN_HI:`MAIN_GAIN_LO];
      watch_ff <= lk_wdata_ff[`MAIN_WATCH_BIT];
      doze_ff <= lk_wdata_ff[`MAIN_DOZE_BIT];
    end
  end

  // Noise, touch and pattern state
  logic [2:0] noisy_ff;
  logic [2:0] touch_prev_ff;
  logic [2:0] contact_ff;
  logic [2:0] lamp_done_ff;
  logic pattern_ff;
  logic group_ff;
  logic [2:0] touch_eff, new_touch, pat_inputs;
  logic [1:0] pat_count;
  logic pat_cond, pat_rise, irq_set;

  always_ff @(posedge clk) begin
    if (rst) begin
      noisy_ff <= 3'h0;
      group_ff <= 1'b0;
      pattern_ff <= 1'b0;
    end else begin
      noisy_ff <= doze_ff ? 3'h0 : noise_err; // [R17]
      group_ff <= !doze_ff && multi_block;
      pattern_ff <= pat_cond; // [R12]
    end
  end

  // Dropped inputs fall out of touch_eff, giving exactly one release
  assign touch_eff = touch_raw & scan_enable & ~noisy_ff; // [R3] [R16]
  assign new_touch = touch_eff & ~touch_prev_ff;
  assign pat_inputs = above_pattern | noisy_ff; // [R18]
  // Each term is widened first so that a count of two or three is not lost
  assign pat_count = 2'(pat_inputs[0]) + 2'(pat_inputs[1]) + 2'(pat_inputs[2]);
  assign pat_cond = !doze_ff && pattern_en && (pattern_match || pat_count > pattern_thresh);
  assign pat_rise = pat_cond && !pattern_ff;
  // The group block flag has no path into irq_set
  assign irq_set = |(new_touch & irq_enable) || (pat_rise && pattern_irq_enable); // [R8] [R11] [R12]

  always_ff @(posedge clk) begin
    if (rst) begin
      touch_prev_ff <= 3'h0;
    end else begin
      touch_prev_ff <= touch_eff;
    end
  end

  // Still-held touches survive a clear but raise no new interrupt
  always_ff @(posedge clk) begin
    if (rst || doze_enter || doze_ff) begin
      contact_ff <= 3'h0; // [R6]
    end else if (int_clr || (watch_ff && rd_touch)) begin
      contact_ff <= touch_eff; // [R2] [R14]
    end else begin
      contact_ff <= contact_ff | new_touch;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || doze_enter || doze_ff) begin
      lamp_done_ff <= 3'h0;
    end else if (int_clr) begin
      lamp_done_ff <= lamp_done_evt & ~lamp_linked; // [R15]
    end else begin
      lamp_done_ff <= lamp_done_ff | (lamp_done_evt & ~lamp_linked);
    end
  end

  // A new event in the clearing cycle wins over the host clear
  always_ff @(posedge clk) begin
    if (rst || doze_enter) begin
      irq_pending_ff <= 1'b0; // [R6]
      irq_out_n <= 1'b1;
    end else if (irq_set) begin
      irq_pending_ff <= 1'b1; // [R7]
      irq_out_n <= 1'b0; // [R23]
    end else if (int_clr) begin
      irq_pending_ff <= 1'b0; // [R9]
      irq_out_n <= 1'b1;
    end
  end

  // Delta counts, one per input
  logic [7:0] delta_ff [3];
  logic drop_sample;
  logic [7:0] sat_delta;

  assign drop_sample = (sample_lf_noise && !lf_filter_bypass) ||
                       (sample_rf_noise && !rf_filter_bypass); // [R19]

  always_comb begin
    if (sample_delta > `RAW_MAX) begin
      sat_delta = `DELTA_MAX; // [R21]
    end else if (sample_delta < `RAW_MIN) begin
      sat_delta = `DELTA_MIN; // [R21]
    end else begin
      sat_delta = sample_delta[7:0]; // [R20]
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_delta
    always_ff @(posedge clk) begin
      if (rst || noisy_ff[i]) begin
        delta_ff[i] <= 8'h00; // [R16]
      end else if (sample_valid && sample_idx == 2'(i)) begin
        delta_ff[i] <= drop_sample ? 8'h00 : sat_delta; // [R20]
      end
    end
  end

  // Read path
  reg_byte_t rd_mux;

  always_comb begin
    unique case (lk_addr_ff)
      `OFS_MAIN_CONTROL: rd_mux = {gain_ff, watch_ff, doze_ff, 3'h0, irq_pending_ff};
      `OFS_GENERAL_STATUS: rd_mux = {3'h0, |lamp_done_ff, 1'b0, group_ff, pattern_ff,
                                     |contact_ff}; // [R10] [R13] [R23]
      `OFS_INPUT_TOUCH_STATUS: rd_mux = {5'h00, contact_ff};
      `OFS_LAMP_DONE_STATUS: rd_mux = {5'h00, lamp_done_ff};
      `OFS_NOISE_FLAGS: rd_mux = {5'h00, noisy_ff};
      `OFS_INPUT1_DELTA: rd_mux = delta_ff[0];
      `OFS_INPUT2_DELTA: rd_mux = delta_ff[1];
      `OFS_INPUT3_DELTA: rd_mux = delta_ff[2];
      default: rd_mux = `UNMAPPED_BYTE; // [R22]
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= `RESET_BYTE;
      ack_tgl_ff <= 1'b0;
    end else if (acc_go) begin
      rdata_ff <= acc_rd ? rd_mux : `RESET_BYTE;
      ack_tgl_ff <= ~ack_tgl_ff;
    end
  end

  // Power state outputs, one cycle behind the control bits
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_enable <= 3'h7;
      gain_factor <= 4'h1;
      lamp_follow <= 3'h0;
      lamp_idle <= 1'b0;
      pwm_enable <= 1'b1;
    end else begin
      unique case (mode)
        PWR_ACTIVE: scan_enable <= 3'h7;
        PWR_WATCH: scan_enable <= standby_chan; // [R2]
        PWR_DOZE: scan_enable <= 3'h0; // [R5]
      endcase
      gain_factor <= 4'(4'h1 << gain_ff); // [R1]
      lamp_follow <= (mode == PWR_DOZE) ? 3'h0 : lamp_linked; // [R4]
      lamp_idle <= mode == PWR_DOZE; // [R5]
      pwm_enable <= mode != PWR_DOZE; // [R5]
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_doze_write;
    doze_enter;
  endsequence
  sequence s_all_clear;
    !irq_pending_ff && contact_ff == 3'h0 && lamp_done_ff == 3'h0;
  endsequence

  chk_doze_clear_all: assert property (s_doze_write |=> s_all_clear) // [R6]
    else $error("doze entry left status set");
  chk_irq_pin_level: assert property (irq_out_n == !irq_pending_ff) // [R7]
    else $error("alert pin disagrees with pending bit");
  chk_masked_touch: assert property ( // [R8]
    !irq_pending_ff && (new_touch & irq_enable) == 3'h0 && !pat_rise |=> !irq_pending_ff)
    else $error("pending set without enabled cause");
  chk_host_clear_irq: assert property (int_clr && !irq_set |=> irq_out_n) // [R9]
    else $error("alert not released on clear");
  chk_gain_decode: assert property (##1 gain_factor == 4'(4'h1 << $past(gain_ff))) // [R1]
    else $error("gain factor wrong");
  chk_doze_outputs: assert property (doze_ff |=> scan_enable == 3'h0 && lamp_idle && !pwm_enable) // [R5]
    else $error("doze outputs wrong");
  chk_noise_zero: assert property (noisy_ff[0] |=> delta_ff[0] == 8'h00) // [R16]
    else $error("noisy delta not zero");
  chk_delta_sat: assert property ( // [R21]
    sample_valid && sample_idx == 2'h2 && !drop_sample && !noisy_ff[2] &&
    sample_delta > `RAW_MAX |=> delta_ff[2] == `DELTA_MAX)
    else $error("delta not saturated");
  // Doze entry in the clearing write wipes the touch bits on purpose
  chk_held_touch: assert property ( // [R14]
    int_clr && !doze_enter && !doze_ff && touch_eff[0] |=> contact_ff[0])
    else $error("held touch bit cleared");

endmodule

// [tb/link_host.sv]
/*
  Behavioural serial engine that issues register accesses on link_clk.
  Assumes the bench calls access only after both resets are released.
*/
`timescale 1ns/100ps
module link_host (
  input wire logic link_clk,
  input wire logic lk_ack,
  input wire logic [7:0] lk_rdata,
  output logic lk_req,
  output logic lk_wr,
  output logic [7:0] lk_addr,
  output logic [7:0] lk_wdata
);
  initial begin
    lk_req = 1'b0;
    lk_wr = 1'b0;
    lk_addr = 8'hFF;
    lk_wdata = 8'hFF;
  end
  // Strictly one access in flight; gap idles the engine to act slowly
  task automatic access(input int gap, input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output bit lost);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge link_clk);
    #1;
    lk_req = 1'b1;
    lk_wr = wr;
    lk_addr = a;
    lk_wdata = d;
    @(posedge link_clk);
    #1;
    lk_req = 1'b0;
    while (lk_ack !== 1'b1 && n < 40) begin
      @(posedge link_clk);
      #1;
      n++;
    end
    lost = (n >= 40);
    q = lk_rdata;
    @(posedge link_clk);
    #1;
    // Released lines must not look like the last access
    lk_addr = ~a;
    lk_wdata = ~d;
  endtask
endmodule

// [tb/tb.sv]
/*
  Self-checking bench for the touch register bank.
  Assumes link_host as the serial engine and a 250 MHz core clock.
*/
`timescale 1ns/100ps
`include "touch_defines.svh"
module tb
  import touch_pkg::*;
;
  logic clk = 0, rst = 1, link_clk = 0, lk_rst = 1, lk_req, lk_wr, lk_ack;
  logic [7:0] lk_addr, lk_wdata, lk_rdata;
  logic sample_valid, sample_lf_noise, sample_rf_noise, lf_filter_bypass, rf_filter_bypass;
  logic [1:0] sample_idx, pattern_thresh;
  logic signed [15:0] sample_delta;
  logic [2:0] noise_err, touch_raw, irq_enable, standby_chan, above_pattern;
  logic [2:0] lamp_linked, lamp_done_evt, scan_enable, lamp_follow;
  logic multi_block, pattern_en, pattern_match, pattern_irq_enable;
  logic lamp_idle, pwm_enable, irq_out_n;
  logic [3:0] gain_factor;
  int miscompares = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  always #7.5 link_clk = ~link_clk;
  touch_ctrl_status_regs i_dut (.clk, .rst, .link_clk, .lk_rst, .lk_req, .lk_wr, .lk_addr,
    .lk_wdata, .lk_ack, .lk_rdata, .sample_valid, .sample_idx, .sample_delta,
    .sample_lf_noise, .sample_rf_noise, .lf_filter_bypass, .rf_filter_bypass, .noise_err,
    .touch_raw, .irq_enable, .standby_chan, .multi_block, .pattern_en, .pattern_match,
    .above_pattern, .pattern_thresh, .pattern_irq_enable, .lamp_linked, .lamp_done_evt,
    .scan_enable, .gain_factor, .lamp_follow, .lamp_idle, .pwm_enable, .irq_out_n);
  link_host i_host (.link_clk, .lk_ack, .lk_rdata, .lk_req, .lk_wr, .lk_addr, .lk_wdata);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input reg_byte_t seen, input reg_byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic acc(input int g, input logic w, input reg_byte_t a, input reg_byte_t d,
      output reg_byte_t q);
    bit lost;
    i_host.access(g, w, a, d, q, lost);
    if (lost) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic rd(input reg_byte_t a, input reg_byte_t e, input string what);
    reg_byte_t q;
    acc(0, 1'b0, a, 8'h00, q);
    check(what, q, e);
  endtask
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    reg_byte_t q;
    acc(3, 1'b1, a, d, q);
    step(3);
  endtask
  task automatic irq_is(input logic e, input string what);
    int n;
    n = 0;
    while (irq_out_n !== e && n < 20) begin
      step(1);
      n++;
    end
    check(what, {7'h00, irq_out_n}, {7'h00, e});
    if (irq_out_n !== e) end_of_test();
  endtask
  task automatic smp(input logic [1:0] i, input logic signed [15:0] v, input logic lf,
      input logic rf);
    step(1);
    sample_valid = 1'b1;
    sample_idx = i;
    sample_delta = v;
    sample_lf_noise = lf;
    sample_rf_noise = rf;
    step(1);
    sample_valid = 1'b0;
    sample_lf_noise = 1'b0;
    sample_rf_noise = 1'b0;
    step(2);
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    reg_byte_t offs[8] = '{`OFS_MAIN_CONTROL, `OFS_GENERAL_STATUS, `OFS_INPUT_TOUCH_STATUS,
      `OFS_LAMP_DONE_STATUS, `OFS_NOISE_FLAGS, `OFS_INPUT1_DELTA, `OFS_INPUT2_DELTA,
      `OFS_INPUT3_DELTA};
    logic signed [15:0] sat_in[4] = '{16'sd127, 16'sd128, -16'sd128, -16'sd129};
    reg_byte_t sat_exp[4] = '{8'h7F, 8'h7F, 8'h80, 8'h80};
    {sample_valid, sample_lf_noise, sample_rf_noise, lf_filter_bypass, rf_filter_bypass} = '0;
    {sample_idx, pattern_thresh, sample_delta, noise_err, touch_raw, irq_enable} = '0;
    {standby_chan, above_pattern, lamp_linked, lamp_done_evt} = '0;
    {multi_block, pattern_en, pattern_match, pattern_irq_enable} = '0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    lk_rst = 1'b0;
    step(4);
    check("alert idle", {7'h00, irq_out_n}, 8'h01);
    for (int k = 0; k < 8; k++) rd(offs[k], `RESET_BYTE, "reset value");
    wr(8'h01, 8'hFF);
    wr(`OFS_INPUT_TOUCH_STATUS, 8'hFF);
    rd(8'h01, `UNMAPPED_BYTE, "unmapped");
    rd(`OFS_INPUT_TOUCH_STATUS, 8'h00, "read-only");
    for (int g = 0; g < 4; g++) begin
      wr(`OFS_MAIN_CONTROL, {g[1:0], 6'h0E});
      rd(`OFS_MAIN_CONTROL, {g[1:0], 6'h00}, "gain readback");
      check("gain", {4'h0, gain_factor}, 8'h01 << g);
    end
    wr(`OFS_MAIN_CONTROL, 8'h00);
    irq_enable = 3'b111;
    touch_raw = 3'b001;
    irq_is(1'b0, "alert on touch");
    rd(`OFS_INPUT_TOUCH_STATUS, 8'h01, "touch bit");
    rd(`OFS_GENERAL_STATUS, 8'h01, "contact summary");
    rd(`OFS_MAIN_CONTROL, 8'h01, "pending bit");
    wr(`OFS_MAIN_CONTROL, 8'h00);
    irq_is(1'b1, "alert cleared");
    rd(`OFS_INPUT_TOUCH_STATUS, 8'h01, "held touch");
    check("no re-raise", {7'h00, irq_out_n}, 8'h01);
    touch_raw = 3'b000;
    wr(`OFS_MAIN_CONTROL, 8'h00);
    rd(`OFS_INPUT_TOUCH_STATUS, 8'h00, "touch gone");
    rd(`OFS_GENERAL_STATUS, 8'h00, "summary gone");
    irq_enable = 3'b101;
    touch_raw = 3'b010;
    step(10);
    check("masked touch", {7'h00, irq_out_n}, 8'h01);
    touch_raw = 3'b000;
    multi_block = 1'b1;
    wr(`OFS_MAIN_CONTROL, 8'h00);
    rd(`OFS_GENERAL_STATUS, 8'h04, "group flag");
    check("group no alert", {7'h00, irq_out_n}, 8'h01);
    step(1);
    multi_block = 1'b0;
    pattern_en = 1'b1;
    pattern_match = 1'b1;
    step(3);
    rd(`OFS_GENERAL_STATUS, 8'h02, "pattern flag");
    check("pattern no alert", {7'h00, irq_out_n}, 8'h01);
    step(1);
    pattern_match = 1'b0;
    step(3);
    rd(`OFS_GENERAL_STATUS, 8'h00, "pattern gone");
    step(1);
    pattern_irq_enable = 1'b1;
    pattern_match = 1'b1;
    irq_is(1'b0, "pattern alert");
    pattern_match = 1'b0;
    wr(`OFS_MAIN_CONTROL, 8'h00);
    lamp_done_evt = 3'b100;
    step(1);
    lamp_done_evt = 3'b000;
    step(2);
    rd(`OFS_LAMP_DONE_STATUS, 8'h04, "lamp done");
    rd(`OFS_GENERAL_STATUS, 8'h10, "lamp summary");
    wr(`OFS_MAIN_CONTROL, 8'h00);
    rd(`OFS_LAMP_DONE_STATUS, 8'h00, "lamp cleared");
    noise_err = 3'b001;
    step(2);
    rd(`OFS_NOISE_FLAGS, 8'h01, "noise flag");
    smp(2'd0, 16'sd50, 1'b0, 1'b0);
    rd(`OFS_INPUT1_DELTA, 8'h00, "noisy delta");
    noise_err = 3'b000;
    step(2);
    rd(`OFS_NOISE_FLAGS, 8'h00, "noise gone");
    smp(2'd1, -16'sd5, 1'b0, 1'b0);
    rd(`OFS_INPUT2_DELTA, 8'hFB, "signed delta");
    for (int k = 0; k < 4; k++) begin
      smp(2'd2, sat_in[k], 1'b0, 1'b0);
      rd(`OFS_INPUT3_DELTA, sat_exp[k], "saturation");
    end
    smp(2'd1, 16'sd20, 1'b1, 1'b0);
    rd(`OFS_INPUT2_DELTA, 8'h00, "lf dropped");
    lf_filter_bypass = 1'b1;
    smp(2'd1, 16'sd20, 1'b1, 1'b0);
    rd(`OFS_INPUT2_DELTA, 8'h14, "lf kept");
    smp(2'd2, 16'sd20, 1'b0, 1'b1);
    rd(`OFS_INPUT3_DELTA, 8'h00, "rf dropped");
    rf_filter_bypass = 1'b1;
    smp(2'd2, 16'sd20, 1'b0, 1'b1);
    rd(`OFS_INPUT3_DELTA, 8'h14, "rf kept");
    touch_raw = 3'b001;
    irq_is(1'b0, "alert before doze");
    touch_raw = 3'b000;
    wr(`OFS_MAIN_CONTROL, 8'h10);
    rd(`OFS_INPUT_TOUCH_STATUS, 8'h00, "doze clears status");
    rd(`OFS_MAIN_CONTROL, 8'h10, "doze clears pending");
    check("doze alert", {7'h00, irq_out_n}, 8'h01);
    check("doze lamps", {6'h00, lamp_idle, pwm_enable}, 8'h02);
    check("doze scan", {5'h00, scan_enable}, 8'h00);
    standby_chan = 3'b010;
    wr(`OFS_MAIN_CONTROL, 8'h20);
    check("watch scan", {5'h00, scan_enable}, 8'h02);
    touch_raw = 3'b010;
    step(3);
    touch_raw = 3'b000;
    step(3);
    rd(`OFS_INPUT_TOUCH_STATUS, 8'h02, "watch touch held");
    rd(`OFS_INPUT_TOUCH_STATUS, 8'h00, "watch read clears");
    wr(`OFS_MAIN_CONTROL, 8'h00);
    check("active scan", {5'h00, scan_enable}, 8'h07);
    lamp_linked = 3'b101;
    pattern_thresh = 2'd1;
    above_pattern = 3'b001;
    noise_err = 3'b001;
    step(3);
    check("linked lamps", {5'h00, lamp_follow}, 8'h05);
    rd(`OFS_GENERAL_STATUS, 8'h00, "noise counted once");
    noise_err = 3'b011;
    step(3);
    rd(`OFS_GENERAL_STATUS, 8'h02, "noise pattern");
    end_of_test();
  end
endmodule
